// ### ess_pkg.sv
// Constants and types for the event status summary register bank
package ess_pkg;

  // Standard event flag positions
  localparam int EsfOpComplete = 0;
  localparam int EsfQueryError = 2;
  localparam int EsfDeviceError = 3;
  localparam int EsfExecError = 4;
  localparam int EsfCommandError = 5;
  localparam int EsfUserRequest = 6;
  localparam int EsfPowerOn = 7;

  // Questionable condition positions
  localparam int QcfPower = 3;
  localparam int QcfTimebaseCold = 4;
  localparam int QcfFrequency = 5;
  localparam int QcfModulation = 6 + 1;
  localparam int QcfUncal = 8;
  localparam int QcfSelfTest = 9;
  localparam int QcfAlwaysZero = 15;

  // Implemented bits; everything else reads as zero
  localparam logic [7:0] EsfUsedMask = 8'hFD;
  localparam logic [15:0] QcfUsedMask = 16'h03B8;

  // Reset values: only the power-on event is present after reset
  localparam logic [7:0] EsfResetValue = 8'h80;
  localparam logic [7:0] EseResetValue = 8'h00;
  localparam logic [15:0] QcfResetValue = 16'h0000;

  // Device-specific error code window
  localparam logic signed [15:0] DevErrLow = -16'sd399;
  localparam logic signed [15:0] DevErrHigh = -16'sd300;

  // Command codes on the command port
  typedef enum logic [3:0] {
    ESS_OP_NOP = 4'h0,
    ESS_OP_READ_EVENTS = 4'h1,
    ESS_OP_WRITE_ENABLE = 4'h2,
    ESS_OP_READ_ENABLE = 4'h3,
    ESS_OP_READ_QUES_COND = 4'h4,
    ESS_OP_READ_QUES_EVENT = 4'h5,
    ESS_OP_WRITE_QUES_ENABLE = 4'h6,
    ESS_OP_READ_QUES_ENABLE = 4'h7,
    ESS_OP_OP_COMPLETE = 4'h8
  } ess_op_t;

  typedef struct packed {
    logic valid;
    ess_op_t op;
    logic [15:0] data;
  } ess_cmd_t;

  typedef struct packed {
    logic powerBad;
    logic timebaseCold;
    logic freqBad;
    logic modBad;
    logic uncal;
    logic selfTestFail;
  } ess_cond_t;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } ess_rsp_t;

endpackage : ess_pkg

// ### ess_event_status_summary.sv
// Standard event and questionable condition registers with summary bits
//
// Behaviour
// - Enabled rising event flag sets summary bit
// - Event flags query returns flag contents
// - Enable mask settable and queryable, per bit
// - Bit 0 after completion command and idle
// - Bit 2 on stray read or unfetched reply
// - Bit 3 on error -300..-399 or positive
// - Bit 4 on execution failure, error queued
// - Bit 5 on syntax error, error queued
// - Bit 6 on switch to local control
// - Bit 7 set at power up
// - Questionable condition and event both queryable
// - Questionable bit 3 while power setting bad
// - Questionable bit 4 while time base cold
// - Questionable bit 5 on frequency error
// - Questionable bit 7 while modulation bad
// - Questionable bit 8 while uncalibrated
// - Questionable bit 9 on self-test failure
// - Questionable bit 15 always reads zero
// - Event bits set by device, cleared on read
// - Reading enable masks leaves them unchanged
// - Status bit 3 is OR of enabled events
`timescale 1ns/1ps
module ess_event_status_summary
  import ess_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Command port
  input wire ess_cmd_t cmd,
  output ess_rsp_t rsp,
  // Events from the command engine
  input wire logic allIdle,
  input wire logic readWithoutQuery,
  input wire logic cmdBeforeFetch,
  input wire logic errLogged,
  input wire logic signed [15:0] errLogCode,
  input wire logic execFail,
  input wire logic syntaxFail,
  input wire logic signed [15:0] failCode,
  input wire logic localSwitch,
  // Instrument conditions, asynchronous
  input wire ess_cond_t cond,
  // Summary and error queue outputs
  output logic eventSummaryBit,
  output logic quesSummaryBit,
  output logic errPush,
  output logic signed [15:0] errPushCode
);

  function automatic logic isDeviceError(input logic signed [15:0] code);
    isDeviceError = ((code >= DevErrLow) && (code <= DevErrHigh)) || (code > 16'sd0);
  endfunction : isDeviceError

  function automatic logic isOp(input ess_cmd_t c, input ess_op_t o);
    isOp = c.valid && (c.op == o);
  endfunction : isOp

  logic [7:0] esfReg, esfNext;
  logic [7:0] eseReg, eseNext;
  logic [15:0] qevReg, qevNext;
  logic [15:0] qenReg, qenNext;
  logic [15:0] qcondMetaReg, qcondMetaNext;
  logic [15:0] qcondReg, qcondNext;
  logic [15:0] qcondPrevReg, qcondPrevNext;
  logic opcPendReg, opcPendNext;
  ess_rsp_t rspReg, rspNext;
  logic evSumReg, evSumNext;
  logic qSumReg, qSumNext;
  logic errPushReg, errPushNext;
  logic signed [15:0] errCodeReg, errCodeNext;
  logic [7:0] esfSet;
  logic [15:0] qcondRaw;

  always_comb begin
    qcondRaw = 16'h0000;
    qcondRaw[QcfPower] = cond.powerBad;
    qcondRaw[QcfTimebaseCold] = cond.timebaseCold;
    qcondRaw[QcfFrequency] = cond.freqBad;
    qcondRaw[QcfModulation] = cond.modBad;
    qcondRaw[QcfUncal] = cond.uncal;
    qcondRaw[QcfSelfTest] = cond.selfTestFail;
  end

  always_comb begin
    esfSet = 8'h00;
    esfSet[EsfQueryError] = readWithoutQuery || cmdBeforeFetch;
    esfSet[EsfDeviceError] = errLogged && isDeviceError(errLogCode);
    esfSet[EsfExecError] = execFail;
    esfSet[EsfCommandError] = syntaxFail;
    esfSet[EsfUserRequest] = localSwitch;
    esfSet[EsfOpComplete] = opcPendReg && allIdle;
  end

  always_comb begin
    qcondMetaNext = qcondRaw;
    qcondNext = qcondMetaReg & QcfUsedMask;
    qcondPrevNext = qcondReg;
    opcPendNext = opcPendReg;
    if (isOp(cmd, ESS_OP_OP_COMPLETE)) begin
      opcPendNext = 1'b1;
    end else if (opcPendReg && allIdle) begin
      opcPendNext = 1'b0;
    end
    // A set arriving with the clearing read wins, so no event is lost
    esfNext = esfReg;
    if (isOp(cmd, ESS_OP_READ_EVENTS)) begin
      esfNext = 8'h00;
    end
    esfNext = (esfNext | esfSet) & EsfUsedMask;
    qevNext = qevReg;
    if (isOp(cmd, ESS_OP_READ_QUES_EVENT)) begin
      qevNext = 16'h0000;
    end
    qevNext = (qevNext | (qcondReg & ~qcondPrevReg)) & QcfUsedMask;
    eseNext = eseReg;
    if (isOp(cmd, ESS_OP_WRITE_ENABLE)) begin
      eseNext = cmd.data[7:0] & EsfUsedMask;
    end
    qenNext = qenReg;
    if (isOp(cmd, ESS_OP_WRITE_QUES_ENABLE)) begin
      qenNext = cmd.data & QcfUsedMask;
    end
    rspNext.valid = 1'b0;
    rspNext.data = 16'h0000;
    if (cmd.valid) begin
      rspNext.valid = 1'b1;
      unique case (cmd.op)
        ESS_OP_READ_EVENTS: rspNext.data = {8'h00, esfReg};
        ESS_OP_READ_ENABLE: rspNext.data = {8'h00, eseReg};
        ESS_OP_READ_QUES_COND: rspNext.data = qcondReg;
        ESS_OP_READ_QUES_EVENT: rspNext.data = qevReg;
        ESS_OP_READ_QUES_ENABLE: rspNext.data = qenReg;
        default: rspNext.valid = 1'b0;
      endcase
    end
    // Level summary: any set flag whose enable bit is set raises it, one edge later
    evSumNext = |(esfReg & eseReg);
    qSumNext = |(qevReg & qenReg);
    errPushNext = execFail || syntaxFail;
    errCodeNext = (execFail || syntaxFail) ? failCode : 16'sd0;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      esfReg <= EsfResetValue;
      eseReg <= EseResetValue;
      qevReg <= QcfResetValue;
      qenReg <= QcfResetValue;
      qcondMetaReg <= QcfResetValue;
      qcondReg <= QcfResetValue;
      qcondPrevReg <= QcfResetValue;
      opcPendReg <= 1'b0;
      rspReg <= '0;
      evSumReg <= 1'b0;
      qSumReg <= 1'b0;
      errPushReg <= 1'b0;
      errCodeReg <= 16'sd0;
    end else begin
      esfReg <= esfNext;
      eseReg <= eseNext;
      qevReg <= qevNext;
      qenReg <= qenNext;
      qcondMetaReg <= qcondMetaNext;
      qcondReg <= qcondNext;
      qcondPrevReg <= qcondPrevNext;
      opcPendReg <= opcPendNext;
      rspReg <= rspNext;
      evSumReg <= evSumNext;
      qSumReg <= qSumNext;
      errPushReg <= errPushNext;
      errCodeReg <= errCodeNext;
    end
  end

  assign rsp = rspReg;
  assign eventSummaryBit = evSumReg;
  assign quesSummaryBit = qSumReg;
  assign errPush = errPushReg;
  assign errPushCode = errCodeReg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  chk_event_summary_rise: assert property (
    (esfReg[EsfExecError] == 1'b0) ##1 (esfReg[EsfExecError] && eseReg[EsfExecError])
    |=> eventSummaryBit) else $error("summary bit not raised by enabled event");

  chk_event_query_data: assert property (
    isOp(cmd, ESS_OP_READ_EVENTS) |=> rsp.valid && (rsp.data == {8'h00, $past(esfReg)}))
    else $error("event query returned wrong data");

  chk_enable_write_read: assert property (
    isOp(cmd, ESS_OP_WRITE_ENABLE) ##1 isOp(cmd, ESS_OP_READ_ENABLE)
    |=> rsp.data[7:0] == ($past(cmd.data[7:0], 2) & EsfUsedMask))
    else $error("enable mask readback mismatch");

  chk_opc_complete: assert property (
    opcPendReg && allIdle
    |=> esfReg[EsfOpComplete] && (opcPendReg == $past(isOp(cmd, ESS_OP_OP_COMPLETE))))
    else $error("operation complete not flagged");

  chk_query_error: assert property (
    readWithoutQuery || cmdBeforeFetch |=> esfReg[EsfQueryError])
    else $error("query error not flagged");

  chk_device_error: assert property (
    errLogged && !isDeviceError(errLogCode) && !esfReg[EsfDeviceError]
    |=> !esfReg[EsfDeviceError]) else $error("device error set for wrong code");

  chk_exec_queue: assert property (
    execFail |=> esfReg[EsfExecError] && errPush && (errPushCode == $past(failCode)))
    else $error("execution error not flagged or queued");

  chk_syntax_queue: assert property (
    syntaxFail |=> esfReg[EsfCommandError] && errPush)
    else $error("command error not flagged or queued");

  chk_local_switch: assert property (
    localSwitch |=> esfReg[EsfUserRequest]) else $error("user request not flagged");

  chk_ques_bit_zero: assert property (
    !qevReg[QcfAlwaysZero] && !qcondReg[QcfAlwaysZero] && (qevReg & ~QcfUsedMask) == 16'h0000)
    else $error("unused questionable bit set");

  chk_read_clears: assert property (
    isOp(cmd, ESS_OP_READ_EVENTS) && (esfSet == 8'h00) |=> esfReg == 8'h00)
    else $error("event read did not clear flags");

  chk_enable_stable: assert property (
    isOp(cmd, ESS_OP_READ_ENABLE) |=> $stable(eseReg)) else $error("enable read changed mask");

  chk_ques_summary: assert property (
    |(qevReg & qenReg) |=> quesSummaryBit) else $error("questionable summary missing");

  chk_unused_zero: assert property (
    (esfReg & ~EsfUsedMask) == 8'h00 && (eseReg & ~EsfUsedMask) == 8'h00)
    else $error("unused event bit set");

  chk_ques_latch: assert property (
    $rose(cond.powerBad) |-> ##3 qevReg[QcfPower]) else $error("questionable event not latched");

  chk_reset_values: assert property (
    $rose(rst_b) |-> (esfReg == EsfResetValue) && (eseReg == EseResetValue) && !rsp.valid)
    else $error("register not at reset value");

  chk_device_set: assert property (
    errLogged && isDeviceError(errLogCode) |=> esfReg[EsfDeviceError])
    else $error("device error not flagged");

  chk_opc_pending: assert property (
    isOp(cmd, ESS_OP_OP_COMPLETE) |=> opcPendReg)
    else $error("completion command not held pending");

  chk_error_code_idle: assert property (
    !execFail && !syntaxFail
    |=> !errPush && (errPushCode == 16'sd0))
    else $error("error queue pushed without a failure");

  chk_idle_no_answer: assert property (
    !cmd.valid
    |=> !rsp.valid && (rsp.data == 16'h0000))
    else $error("answer without a command");

  chk_write_no_answer: assert property (
    cmd.valid && (cmd.op inside {ESS_OP_NOP, ESS_OP_WRITE_ENABLE, ESS_OP_OP_COMPLETE,
      ESS_OP_WRITE_QUES_ENABLE}) |=> !rsp.valid)
    else $error("write produced an answer");

  chk_summary_low: assert property (
    (esfReg & eseReg) == 8'h00 |=> !eventSummaryBit)
    else $error("summary bit set without enabled event");

  chk_event_hold: assert property (
    !isOp(cmd, ESS_OP_READ_EVENTS)
    |=> ((esfReg & $past(esfReg)) == $past(esfReg)))
    else $error("event flag lost without a read");

  // Checked at the first stage, one edge after the pin is sampled
  chk_cond_map: assert property (
    1'b1 |=> (qcondMetaReg[QcfPower] == $past(cond.powerBad))
      && (qcondMetaReg[QcfTimebaseCold] == $past(cond.timebaseCold))
      && (qcondMetaReg[QcfFrequency] == $past(cond.freqBad))
      && (qcondMetaReg[QcfModulation] == $past(cond.modBad))
      && (qcondMetaReg[QcfUncal] == $past(cond.uncal))
      && (qcondMetaReg[QcfSelfTest] == $past(cond.selfTestFail)))
    else $error("condition bit map wrong");

  chk_ques_cond_query: assert property (
    isOp(cmd, ESS_OP_READ_QUES_COND) |=> rsp.valid && (rsp.data == $past(qcondReg)))
    else $error("condition query returned wrong data");

  chk_ques_event_query: assert property (
    isOp(cmd, ESS_OP_READ_QUES_EVENT) |=> rsp.valid && (rsp.data == $past(qevReg)))
    else $error("questionable event query returned wrong data");

  chk_ques_enable_query: assert property (
    isOp(cmd, ESS_OP_READ_QUES_ENABLE)
    |=> rsp.valid && (rsp.data == $past(qenReg)) && $stable(qenReg))
    else $error("questionable enable readback wrong");

  chk_ques_enable_write: assert property (
    isOp(cmd, ESS_OP_WRITE_QUES_ENABLE) |=> qenReg == ($past(cmd.data) & QcfUsedMask))
    else $error("questionable enable write wrong");

  chk_ques_rise_only: assert property (
    1'b1 |=> ((qevReg & ~$past(qevReg)
      & ~($past(qcondReg) & ~$past(qcondPrevReg))) == 16'h0000))
    else $error("questionable event set without a rise");

  chk_ques_hold: assert property (
    !isOp(cmd, ESS_OP_READ_QUES_EVENT)
    |=> ((qevReg & $past(qevReg)) == $past(qevReg)))
    else $error("questionable event lost without a read");

  chk_ques_summary_low: assert property (
    (qevReg & qenReg) == 16'h0000 |=> !quesSummaryBit)
    else $error("questionable summary set without enabled event");

endmodule : ess_event_status_summary

// ### ess_ctrl_model.sv
// Remote controller model driving the command port
`timescale 1ns/1ps
module ess_ctrl_model
  import ess_pkg::*;
(
  // Clock
  input wire logic clk,
  // Command port
  output ess_cmd_t cmd,
  input wire ess_rsp_t rsp
);
  initial cmd = '0;
  // Query or set command; a missing answer comes back unknown so it never matches
  task automatic send(input ess_op_t op, input logic [15:0] d, output logic [15:0] q);
    @(negedge clk);
    cmd <= '{valid: 1'b1, op: op, data: d};
    @(negedge clk);
    // Released data toggles so a stale value cannot pass for a fresh one
    cmd <= '{valid: 1'b0, op: ESS_OP_NOP, data: ~d};
    q = rsp.valid ? rsp.data : 'x;
  endtask : send
  // Two commands on consecutive edges; the answer returned is that of the second
  task automatic sendPair(input ess_op_t op1, input logic [15:0] d1, input ess_op_t op2,
    output logic [15:0] q);
    @(negedge clk);
    cmd <= '{valid: 1'b1, op: op1, data: d1};
    @(negedge clk);
    cmd <= '{valid: 1'b1, op: op2, data: ~d1};
    @(negedge clk);
    cmd <= '{valid: 1'b0, op: ESS_OP_NOP, data: d1};
    q = rsp.valid ? rsp.data : 'x;
  endtask : sendPair
endmodule : ess_ctrl_model

// ### test_event_status_summary.sv
// Self-checking bench for the event status summary registers
`timescale 1ns/1ps
module test_event_status_summary;
  import ess_pkg::*;
`define CHK(a, e) begin nChecks++; if ((a) !== (e)) begin nMismatch++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
  logic clk = 0, rstB = 0, allIdle = 0, event_summary_bit, qsb, errPush;
  logic rwq = 0, cbf = 0, errLogged = 0, execFail = 0, syntaxFail = 0, localSw = 0;
  logic signed [15:0] errLogCode = '0, failCode = '0, errPushCode;
  ess_cmd_t cmd;
  ess_rsp_t rsp;
  ess_cond_t cond = '0, cOld, cNew;
  logic [15:0] q, v;
  int nMismatch = 0, nChecks = 0, cycles = 0;
  int ks[11] = '{0, 1, 2, 2, 2, 2, 2, 2, 3, 4, 5};
  int cs[11] = '{0, 0, -300, -399, -400, -299, 0, 1, -250, -150, 0};
  logic [7:0] es[11] = '{4, 4, 8, 8, 0, 0, 0, 8, 16, 32, 64};
  always #10 clk = ~clk;

  ess_event_status_summary dut (.clk(clk), .rst_b(rstB), .cmd(cmd), .rsp(rsp),
    .allIdle(allIdle), .readWithoutQuery(rwq), .cmdBeforeFetch(cbf),
    .errLogged(errLogged), .errLogCode(errLogCode), .execFail(execFail),
    .syntaxFail(syntaxFail), .failCode(failCode), .localSwitch(localSw), .cond(cond),
    .eventSummaryBit(event_summary_bit), .quesSummaryBit(qsb), .errPush(errPush),
    .errPushCode(errPushCode));
  ess_ctrl_model m (.clk(clk), .cmd(cmd), .rsp(rsp));

  function automatic logic [15:0] qmap(input ess_cond_t c);
    qmap = '0;
    qmap[QcfPower] = c.powerBad;
    qmap[QcfTimebaseCold] = c.timebaseCold;
    qmap[QcfFrequency] = c.freqBad;
    qmap[QcfModulation] = c.modBad;
    qmap[QcfUncal] = c.uncal;
    qmap[QcfSelfTest] = c.selfTestFail;
  endfunction : qmap

  task automatic tallyAndFinish;
    $display("checks %0d mismatches %0d", nChecks, nMismatch);
    if (nMismatch == 0 && nChecks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tallyAndFinish

  // One event input for one cycle, then read back and clear
  task automatic pulse(input int k, input logic signed [15:0] c, input logic [7:0] e);
    @(negedge clk);
    {rwq, cbf, errLogged, execFail, syntaxFail, localSw} <= 6'b10_0000 >> k;
    errLogCode <= c;
    failCode <= c;
    @(negedge clk);
    {rwq, cbf, errLogged, execFail, syntaxFail, localSw} <= '0;
    `CHK(errPush, 1'(k inside {3, 4}))
    if (errPush === 1'b1) `CHK(errPushCode, c)
    @(negedge clk);
    `CHK(event_summary_bit, 1'(e != 0))
    m.send(ESS_OP_READ_EVENTS, 16'h0000, q);
    `CHK(q, {8'h00, e})
    @(negedge clk);
    `CHK(event_summary_bit, 1'b0)
  endtask : pulse

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      nMismatch++;
      tallyAndFinish();
    end
  end

  initial begin
    void'($urandom(32'h7a57_50bb));
    repeat (2) @(negedge clk);
    rstB <= 1'b1;
    m.send(ESS_OP_READ_EVENTS, 16'h0000, q);
    `CHK(q, 16'h0080)
    m.send(ESS_OP_READ_EVENTS, 16'h0000, q);
    `CHK(q, 16'h0000)
    v = 16'($urandom);
    m.sendPair(ESS_OP_WRITE_ENABLE, v, ESS_OP_READ_ENABLE, q);
    `CHK(q, {8'h00, v[7:0] & EsfUsedMask})
    repeat (2) begin
      m.send(ESS_OP_READ_ENABLE, 16'h0000, q);
      `CHK(q, {8'h00, v[7:0] & EsfUsedMask})
    end
    $display("test enable done");
    m.send(ESS_OP_WRITE_ENABLE, 16'h00ff, q);
    cs[7] = $urandom_range(1, 32767);
    for (int i = 0; i < 11; i++)
      pulse(ks[i], 16'(cs[i]), es[i]);
    $display("test events done");
    m.send(ESS_OP_OP_COMPLETE, 16'h0000, q);
    repeat (3) @(negedge clk);
    m.send(ESS_OP_READ_EVENTS, 16'h0000, q);
    `CHK(q, 16'h0000)
    allIdle <= 1'b1;
    @(negedge clk);
    allIdle <= 1'b0;
    m.send(ESS_OP_READ_EVENTS, 16'h0000, q);
    `CHK(q, 16'h0001)
    $display("test completion done");
    m.send(ESS_OP_WRITE_QUES_ENABLE, 16'hffff, q);
    m.send(ESS_OP_READ_QUES_ENABLE, 16'h0000, q);
    `CHK(q, QcfUsedMask)
    cOld = '0;
    for (int i = 0; i < 6; i++) begin
      cNew = (i == 0) ? '1 : ess_cond_t'(6'($urandom));
      cond <= cNew;
      repeat (6) @(negedge clk);
      `CHK(qsb, |qmap(cNew & ~cOld))
      m.send(ESS_OP_READ_QUES_COND, 16'h0000, q);
      `CHK(q, qmap(cNew))
      m.send(ESS_OP_READ_QUES_EVENT, 16'h0000, q);
      `CHK(q, qmap(cNew & ~cOld))
      m.send(ESS_OP_READ_QUES_EVENT, 16'h0000, q);
      `CHK(q, 16'h0000)
      cOld = cNew;
    end
    $display("test questionable done");
    tallyAndFinish();
  end
endmodule : test_event_status_summary
